/* logic/tcmc_pkg.sv */
/*
 timecode mode controller package: mode codes, register offsets, field
 positions, reset values and timing counts.
 assumes a 100 MHz system clock and the plain register port of the top.
*/
// Contract
// R1 - Timecode is received on the input port and sent on the output port.
// R2 - Mode off: nothing embedded in files, nothing driven on output.
// R3 - Free run: counter always advances, output always driven (code: with stop-mute on, driven only while recording or paused).
// R4 - Free and record run accept jam and restart loads of the counter.
// R5 - Record run: counter advances only while recording.
// R6 - Record run: counter freezes on record stop and on mode entry.
// R7 - Clock run: counter runs; loaded from clock at power-up, change, entry.
// R8 - Chase modes: counter follows incoming timecode.
// R9 - Auto-record chase: recording starts when valid input code appears.
// R10 - Auto-record chase: recording ends when input code ceases.
// R11 - Stop-mute option decides output drive while recording is stopped.
// R12 - Output keeps running during pause even with stop-mute on.
// R13 - Stop-mute is unavailable in off and chase modes.
// R14 - Continuity in chase: generate internally while input is absent.
// R15 - Clock sync option locks the audio clock to incoming timecode.
// R16 - With sync on and input absent, audio clock uses internal source.
// R17 - Continuity and sync unavailable in off and internal modes.
// R18 - Generated timecode is stored with the recorded audio.
// R19 - Six modes encoded in three bits, zero meaning off.
// R20 - Jam loads the counter with the value received on the input.
package tcmc_pkg;

   // ==========================================================
   // modes
   typedef enum logic [2:0] {
      TCMC_OFF      = 3'h0,
      TCMC_FREE     = 3'h1,
      TCMC_RECRUN   = 3'h2,
      TCMC_RTCRUN   = 3'h3,
      TCMC_CHASE    = 3'h4,
      TCMC_CHASE_AR = 3'h5
   } tcmc_mode_t;  // R19

   // time of day, binary fields
   typedef struct packed {
      logic [4:0] hours;
      logic [5:0] minutes;
      logic [5:0] seconds;
      logic [4:0] frames;
   } tcmc_time_t;

   // ==========================================================
   // register map (word offsets)
   localparam logic [3:0] TCMC_CTRL_OFS    = 4'h0;
   localparam logic [3:0] TCMC_LOAD_OFS    = 4'h1;
   localparam logic [3:0] TCMC_CMD_OFS     = 4'h2;
   localparam logic [3:0] TCMC_STATUS_OFS  = 4'h3;
   localparam logic [3:0] TCMC_COUNT_OFS   = 4'h4;
   localparam logic [3:0] TCMC_RATE_OFS    = 4'h5;

   // control fields
   localparam int TCMC_MODE_LSB   = 0;
   localparam int TCMC_MUTE_BIT   = 4;
   localparam int TCMC_CONT_BIT   = 5;
   localparam int TCMC_SYNC_BIT   = 6;
   // command fields (write one to act)
   localparam int TCMC_JAM_BIT     = 0;
   localparam int TCMC_RESTART_BIT = 1;
   localparam int TCMC_RTCCHG_BIT  = 2;
   // status fields
   localparam int TCMC_VALID_BIT  = 0;
   localparam int TCMC_AREC_BIT   = 1;
   localparam int TCMC_DRIVE_BIT  = 2;
   localparam int TCMC_INTCLK_BIT = 3;
   localparam int TCMC_EMBED_BIT  = 4;

   localparam logic [31:0] TCMC_CTRL_RST = 32'h0000_0000;

   // ==========================================================
   // timing
   localparam int CLK_HZ            = 100_000_000;
   localparam int TCMC_FPS_DEF      = 30;
   localparam int TCMC_FRAME_CYCLES = CLK_HZ / TCMC_FPS_DEF;
   // input counts as lost after this long without a new frame
   localparam int TCMC_LOSS_MS      = 100;
   localparam int TCMC_LOSS_CYCLES  = (CLK_HZ / 1000) * TCMC_LOSS_MS;

endpackage

/* logic/tcmc_top.sv */
/*
 timecode mode controller: internal counter, chase, auto record,
 output gating, audio clock source select, register port.
 assumes decoded input frames arrive as a pin-domain strobe plus value,
 and that the record/pause state comes from on-chip logic on clk.
*/
// The plain strobed port and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
module tcmc_top
   import tcmc_pkg::*;
#(
   parameter int FRAME_CYCLES = TCMC_FRAME_CYCLES,
   parameter int LOSS_CYCLES  = TCMC_LOSS_CYCLES
)(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        clk_en,
   // register port
   input  wire logic [3:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [31:0] reg_rdata,
   // timecode input port (pin domain)
   input  wire logic        tc_in_strobe,
   input  tcmc_time_t       tc_in_value,
   // real-time clock
   input  tcmc_time_t       rtc_time,
   // recorder state
   input  wire logic        recording,
   input  wire logic        paused,
   // timecode output port
   output tcmc_time_t       tc_out_value,
   output logic             tc_out_enable,
   output logic             tc_out_frame,
   // recorder control and file stamping
   output logic             auto_rec_start,
   output logic             auto_rec_stop,
   output tcmc_time_t       file_tc,
   output logic             file_tc_valid,
   // audio sample clock source: 1 = locked to incoming code
   output logic             audio_clk_ext
);

   // ==========================================================
   // registers
   tcmc_mode_t  mode_reg;
   tcmc_mode_t  prev_mode_reg;
   logic        mute_reg, cont_reg, sync_reg;
   tcmc_time_t  load_reg;
   logic [4:0]  fps_reg;
   tcmc_time_t  count_reg;
   logic [31:0] tick_cnt_reg;
   logic        rec_d_reg;
   logic        pow_reg;

   logic        is_int, is_chase;
   assign is_int   = (mode_reg == TCMC_FREE) || (mode_reg == TCMC_RECRUN)
                     || (mode_reg == TCMC_RTCRUN);
   assign is_chase = (mode_reg == TCMC_CHASE)
                     || (mode_reg == TCMC_CHASE_AR);

   logic cmd_jam, cmd_restart, cmd_rtcchg;
   logic wr_cmd;
   assign wr_cmd      = reg_wr && (reg_addr == TCMC_CMD_OFS);
   assign cmd_jam     = wr_cmd && reg_wdata[TCMC_JAM_BIT];
   assign cmd_restart = wr_cmd && reg_wdata[TCMC_RESTART_BIT];
   assign cmd_rtcchg  = wr_cmd && reg_wdata[TCMC_RTCCHG_BIT];

   // ==========================================================
   // input synchroniser: strobe toggles are not assumed, strobe is a
   // level held at least two clocks by the decoder
   logic       strb_s1_reg, strb_s2_reg, strb_s3_reg;
   tcmc_time_t in_s1_reg, in_s2_reg;
   always_ff @(posedge clk) begin
      if (reset) begin
         strb_s1_reg <= 1'b0;
         strb_s2_reg <= 1'b0;
         strb_s3_reg <= 1'b0;
         in_s1_reg   <= '0;
         in_s2_reg   <= '0;
      end else if (clk_en) begin
         strb_s1_reg <= tc_in_strobe;
         strb_s2_reg <= strb_s1_reg;
         strb_s3_reg <= strb_s2_reg;
         in_s1_reg   <= tc_in_value;
         in_s2_reg   <= in_s1_reg;
      end
   end
   logic in_frame;
   assign in_frame = strb_s2_reg && !strb_s3_reg;  // R1

   // ==========================================================
   // incoming code presence
   logic [31:0] loss_cnt_reg;
   logic        in_valid_reg;
   always_ff @(posedge clk) begin
      if (reset) begin
         loss_cnt_reg <= '0;
         in_valid_reg <= 1'b0;
      end else if (clk_en) begin
         if (in_frame) begin
            loss_cnt_reg <= '0;
            in_valid_reg <= 1'b1;
         end else if (loss_cnt_reg >= 32'(LOSS_CYCLES - 1)) begin
            in_valid_reg <= 1'b0;
         end else begin
            loss_cnt_reg <= loss_cnt_reg + 32'h0000_0001;
         end
      end
   end

   // ==========================================================
   // control register and options
   always_ff @(posedge clk) begin
      if (reset) begin
         mode_reg <= TCMC_OFF;
         mute_reg <= 1'b0;
         cont_reg <= 1'b0;
         sync_reg <= 1'b0;
         load_reg <= '0;
         fps_reg  <= 5'(TCMC_FPS_DEF);
      end else if (clk_en && reg_wr) begin
         if (reg_addr == TCMC_CTRL_OFS) begin
            mode_reg <= tcmc_mode_t'(reg_wdata[TCMC_MODE_LSB +: 3]);
            mute_reg <= reg_wdata[TCMC_MUTE_BIT];
            cont_reg <= reg_wdata[TCMC_CONT_BIT];
            sync_reg <= reg_wdata[TCMC_SYNC_BIT];
         end
         if (reg_addr == TCMC_LOAD_OFS)
            load_reg <= tcmc_time_t'(reg_wdata[21:0]);
         if (reg_addr == TCMC_RATE_OFS && reg_wdata[4:0] != 5'h00)
            fps_reg <= reg_wdata[4:0];
      end
   end

   // options only take effect in modes where they exist
   logic mute_eff, cont_eff, sync_eff;
   assign mute_eff = mute_reg && is_int;  // R13
   assign cont_eff = cont_reg && is_chase;  // R17
   assign sync_eff = sync_reg && is_chase;  // R17

   // ==========================================================
   // frame tick
   logic tick;
   assign tick = (tick_cnt_reg >= 32'(FRAME_CYCLES - 1));
   always_ff @(posedge clk) begin
      if (reset)
         tick_cnt_reg <= '0;
      else if (clk_en)
         tick_cnt_reg <= tick ? '0 : tick_cnt_reg + 32'h0000_0001;
   end

   function automatic tcmc_time_t tc_inc(input tcmc_time_t t,
                                        input logic [4:0] fps);
      tcmc_time_t r;
      r = t;
      if (t.frames >= fps - 5'h01) begin
         r.frames = '0;
         if (t.seconds == 6'h3B) begin
            r.seconds = '0;
            if (t.minutes == 6'h3B) begin
               r.minutes = '0;
               r.hours   = (t.hours == 5'h17) ? 5'h00 : t.hours + 5'h01;
            end else begin
               r.minutes = t.minutes + 6'h01;
            end
         end else begin
            r.seconds = t.seconds + 6'h01;
         end
      end else begin
         r.frames = t.frames + 5'h01;
      end
      return r;
   endfunction

   // ==========================================================
   // internal counter
   logic advance;
   always_comb begin
      unique case (mode_reg)
         TCMC_FREE:   advance = tick;  // R3
         TCMC_RECRUN: advance = tick && recording;  // R5 R6
         TCMC_RTCRUN: advance = tick;  // R7
         TCMC_CHASE, TCMC_CHASE_AR:
            advance = tick && !in_valid_reg && cont_eff;  // R14
         default:     advance = 1'b0;
      endcase
   end

   logic manual_ok;
   assign manual_ok = (mode_reg == TCMC_FREE) || (mode_reg == TCMC_RECRUN);

   always_ff @(posedge clk) begin
      if (reset) begin
         count_reg     <= '0;
         prev_mode_reg <= TCMC_OFF;
         pow_reg       <= 1'b1;
      end else if (clk_en) begin
         prev_mode_reg <= mode_reg;
         pow_reg       <= 1'b0;
         if (mode_reg == TCMC_RTCRUN && (pow_reg || cmd_rtcchg
             || prev_mode_reg != TCMC_RTCRUN))
            count_reg <= rtc_time;  // R7
         else if (manual_ok && cmd_jam)
            count_reg <= in_s2_reg;  // R4 R20
         else if (manual_ok && cmd_restart)
            count_reg <= load_reg;  // R4
         else if (is_chase && in_frame)
            count_reg <= in_s2_reg;  // R8
         else if (advance)
            count_reg <= tc_inc(count_reg, fps_reg);
      end
   end

   // ==========================================================
   // auto record in auto-record chase mode only
   always_ff @(posedge clk) begin
      if (reset) begin
         auto_rec_start <= 1'b0;
         auto_rec_stop  <= 1'b0;
         rec_d_reg      <= 1'b0;
      end else if (clk_en) begin
         rec_d_reg      <= in_valid_reg;
         auto_rec_start <= (mode_reg == TCMC_CHASE_AR)
                           && in_valid_reg && !rec_d_reg;  // R9
         auto_rec_stop  <= (mode_reg == TCMC_CHASE_AR)
                           && !in_valid_reg && rec_d_reg;  // R10
      end
   end

   // ==========================================================
   // outputs: port drive, file stamp, audio clock source
   logic drive;
   always_comb begin
      if (mode_reg == TCMC_OFF)
         drive = 1'b0;  // R2
      else if (mute_eff)
         drive = recording || paused;  // R11 R12
      else
         drive = 1'b1;  // R3
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         tc_out_value  <= '0;
         tc_out_enable <= 1'b0;
         tc_out_frame  <= 1'b0;
         file_tc       <= '0;
         file_tc_valid <= 1'b0;
         audio_clk_ext <= 1'b0;
      end else if (clk_en) begin
         tc_out_value  <= count_reg;  // R1
         tc_out_enable <= drive;
         tc_out_frame  <= drive && tick;
         file_tc       <= count_reg;  // R18
         file_tc_valid <= (mode_reg != TCMC_OFF) && recording;  // R2 R18
         audio_clk_ext <= sync_eff && in_valid_reg;  // R15 R16
      end
   end

   // ==========================================================
   // register read, data in the cycle after the strobe
   always_ff @(posedge clk) begin
      if (reset) begin
         reg_rdata <= '0;
      end else if (clk_en) begin
         reg_rdata <= '0;
         if (reg_rd) begin
            unique case (reg_addr)
               TCMC_CTRL_OFS:
                  reg_rdata <= {25'h0, sync_reg, cont_reg, mute_reg,
                                1'b0, mode_reg};
               TCMC_LOAD_OFS:   reg_rdata <= {10'h000, load_reg};
               TCMC_STATUS_OFS:
                  reg_rdata <= {27'h0, file_tc_valid, audio_clk_ext,
                                tc_out_enable, rec_d_reg, in_valid_reg};
               TCMC_COUNT_OFS:  reg_rdata <= {10'h000, count_reg};
               TCMC_RATE_OFS:   reg_rdata <= {27'h0, fps_reg};
               default:         reg_rdata <= '0;
            endcase
         end
      end
   end

endmodule

/* testbench/tcmc_tc_gen.sv */
/*
 external timecode source: decoded frames with a two-cycle strobe.
 assumes the bench starts and stops it through run.
*/
`timescale 1ns/1ns
module tcmc_tc_gen
   import tcmc_pkg::*;
#(
   parameter int PERIOD = 40
)(
   // clock and control
   input  wire logic clk,
   input  wire logic run,
   // decoded code towards the block
   output logic       tc_in_strobe,
   output tcmc_time_t tc_in_value
);
   int         cnt = 0;
   tcmc_time_t now = 22'h0_2060;
   initial tc_in_strobe = 1'b0;
   initial tc_in_value = 22'h0;
   always @(posedge clk) begin
      if (!run) begin
         cnt          <= 0;
         tc_in_strobe <= 1'b0;
         // lost source: no stale value left on the lines
         tc_in_value  <= ~now;
      end else begin
         cnt          <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
         tc_in_strobe <= cnt < 2;
         tc_in_value  <= now;
         if (cnt == PERIOD - 1)
            now.frames <= (now.frames == 5'h1D) ? 5'h00 : now.frames + 5'h01;
      end
   end
endmodule

/* testbench/tcmc_top_asserts.sv */
/*
 checker for the timecode mode controller top: mode, output gating.
 assumes it is bound to tcmc_top and sees only its ports.
*/
`timescale 1ns/1ns
module tcmc_checker
   import tcmc_pkg::*;
(
   // clock and reset
   input wire logic        clk,
   input wire logic        reset,
   input wire logic        clk_en,
   // register port
   input wire logic [3:0]  reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic        reg_wr,
   // recorder state
   input wire logic        recording,
   input wire logic        paused,
   // outputs
   input tcmc_time_t       tc_out_value,
   input wire logic        tc_out_enable,
   input wire logic        tc_out_frame,
   input wire logic        auto_rec_start,
   input wire logic        auto_rec_stop,
   input wire logic        file_tc_valid,
   input wire logic        audio_clk_ext
);
   // ==========================================================
   // shadow of the control word
   logic [6:0] ctrl_reg;
   logic [2:0] md;
   logic       intm;
   assign md   = ctrl_reg[2:0];
   assign intm = md != 3'h0 && md < 3'h4;
   always_ff @(posedge clk) begin
      if (reset)
         ctrl_reg <= 7'h00;
      else if (clk_en && reg_wr && reg_addr == TCMC_CTRL_OFS)
         ctrl_reg <= reg_wdata[6:0];
   end

   // ==========================================================
   // properties
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   off_quiet_a: assert property ((md == 3'h0)[*2] |->
      !tc_out_enable && !file_tc_valid && !audio_clk_ext)
      else $error("output active in off mode");
   free_drive_a: assert property (
      (md == TCMC_FREE && !ctrl_reg[TCMC_MUTE_BIT])[*2] |-> tc_out_enable)
      else $error("free run output not driven");
   pause_drive_a: assert property (
      (intm && (recording || paused))[*2] |-> tc_out_enable)
      else $error("output not driven while recording or paused");
   file_valid_a: assert property (
      (md != 3'h0 && recording)[*2] |-> file_tc_valid)
      else $error("file stamp missing while recording");
   sync_mode_a: assert property (audio_clk_ext |->
      md[2] || $past(md[2]) || $past(md[2], 2))
      else $error("audio clock locked outside chase");
   arec_mode_a: assert property ((auto_rec_start || auto_rec_stop) |->
      $past(md) == TCMC_CHASE_AR || $past(md, 2) == TCMC_CHASE_AR)
      else $error("auto record pulse outside auto record mode");
   arec_pulse_a: assert property (auto_rec_start |=>
      !auto_rec_start && !auto_rec_stop)
      else $error("auto record start not a lone pulse");
   rec_freeze_a: assert property (
      (md == TCMC_RECRUN && !recording && !reg_wr)[*3]
      |-> $stable(tc_out_value))
      else $error("record run counter moved while stopped");
   frame_drive_a: assert property (tc_out_frame |-> tc_out_enable)
      else $error("frame tick while output idle");

   cover property (auto_rec_start);
   cover property (auto_rec_stop);
   cover property ($rose(audio_clk_ext));
endmodule

bind tcmc_top tcmc_checker u_chk (.clk(clk), .reset(reset),
   .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .recording(recording), .paused(paused),
   .tc_out_value(tc_out_value), .tc_out_enable(tc_out_enable),
   .tc_out_frame(tc_out_frame), .auto_rec_start(auto_rec_start),
   .auto_rec_stop(auto_rec_stop), .file_tc_valid(file_tc_valid),
   .audio_clk_ext(audio_clk_ext));

/* testbench/tcmc_top_bench.sv */
/*
 bench for the timecode mode controller: register tasks, mode tests.
 assumes the design package and a shortened frame and loss count.
*/
`timescale 1ns/1ns
module tcmc_top_bench;
   import tcmc_pkg::*;
   localparam int FR = 20;
   localparam int LS = 100;
   localparam logic [31:0] LD = 32'h0004_5285;
   localparam logic [31:0] R1V = 32'h000A_30E3;
   localparam logic [31:0] R2V = 32'h0012_0003;
   localparam logic [31:0] MK = 32'h003F_FFE0;
   logic clk = 1'b0, reset = 1'b1, clk_en = 1'b1;
   logic [3:0] reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0, reg_rdata, v, w;
   logic reg_wr = 1'b0, reg_rd = 1'b0, recording = 1'b0, paused = 1'b0;
   logic gen_run = 1'b0, tc_in_strobe, tc_out_enable, tc_out_frame;
   logic auto_rec_start, auto_rec_stop, file_tc_valid, audio_clk_ext;
   tcmc_time_t tc_in_value, tc_out_value, file_tc, exp_tc;
   tcmc_time_t rtc_time = 22'h0;
   int checks = 0, n_fail = 0, i;
   always #5 clk = ~clk;

   tcmc_top #(.FRAME_CYCLES(FR), .LOSS_CYCLES(LS)) u_dut (.clk(clk),
      .reset(reset), .clk_en(clk_en), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .tc_in_strobe(tc_in_strobe),
      .tc_in_value(tc_in_value), .rtc_time(rtc_time),
      .recording(recording), .paused(paused), .tc_out_value(tc_out_value),
      .tc_out_enable(tc_out_enable), .tc_out_frame(tc_out_frame),
      .auto_rec_start(auto_rec_start), .auto_rec_stop(auto_rec_stop),
      .file_tc(file_tc), .file_tc_valid(file_tc_valid),
      .audio_clk_ext(audio_clk_ext));
   tcmc_tc_gen #(.PERIOD(40)) u_gen (.clk(clk), .run(gen_run),
      .tc_in_strobe(tc_in_strobe), .tc_in_value(tc_in_value));

   // ==========================================================
   // tasks
   task automatic chk(input string s, input logic [31:0] e, logic [31:0] g);
      checks++;
      if (g !== e) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      tick(1);
      reg_wr    <= 1'b0;
      // one idle edge keeps the next strobe out of this time step
      tick(1);
   endtask
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      tick(1);
      reg_rd   <= 1'b0;
      d = reg_rdata;
      tick(1);
   endtask
   task automatic rc(input string s, logic [3:0] a, logic [31:0] e,
                     logic [31:0] m);
      logic [31:0] d;
      rd(a, d);
      chk(s, e & m, d & m);
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   initial begin
      #100000;
      n_fail++;
      $display("watchdog expired");
      tally_and_finish();
   end

   // ==========================================================
   // tests
   initial begin
      tick(4);
      reset <= 1'b0;
      rc("ctrl", TCMC_CTRL_OFS, TCMC_CTRL_RST, '1);
      wr(4'hF, 32'hFFFF_FFFF);
      rc("unmapped", 4'hF, 32'h0, '1);
      rc("status", TCMC_STATUS_OFS, 32'h0, '1);
      rc("rate", TCMC_RATE_OFS, 32'(TCMC_FPS_DEF), '1);
      wr(TCMC_RATE_OFS, 32'h0);
      rc("rate zero", TCMC_RATE_OFS, 32'(TCMC_FPS_DEF), '1);
      $display("reset test done");
      gen_run <= 1'b1;
      wr(TCMC_CTRL_OFS, 32'h2);
      wr(TCMC_LOAD_OFS, LD);
      wr(TCMC_CMD_OFS, 32'h2);
      rc("restart", TCMC_COUNT_OFS, LD, '1);
      tick(3 * FR);
      rc("frozen", TCMC_COUNT_OFS, LD, '1);
      recording <= 1'b1;
      tick(3 * FR + 5);
      rd(TCMC_COUNT_OFS, v);
      chk("rec advance", 32'h1, {31'h0, v !== LD});
      chk("embed", 32'h1, {31'h0, file_tc_valid});
      recording <= 1'b0;
      tick(2);
      rd(TCMC_COUNT_OFS, v);
      tick(3 * FR);
      rc("stop freeze", TCMC_COUNT_OFS, v, '1);
      chk("out value", v, {10'h0, tc_out_value});
      chk("file stamp", v, {10'h0, file_tc});
      @(negedge tc_in_strobe);
      tick(3);
      exp_tc = tc_in_value;
      wr(TCMC_CMD_OFS, 32'h1);
      rc("jam", TCMC_COUNT_OFS, {10'h0, exp_tc}, '1);
      $display("record run test done");
      wr(TCMC_CTRL_OFS, 32'h1);
      rd(TCMC_COUNT_OFS, v);
      tick(3 * FR);
      rd(TCMC_COUNT_OFS, w);
      chk("free advance", 32'h1, {31'h0, w !== v});
      clk_en <= 1'b0;
      exp_tc = tc_out_value;
      tick(3 * FR);
      chk("enable hold", {10'h0, exp_tc}, {10'h0, tc_out_value});
      clk_en <= 1'b1;
      wr(TCMC_CTRL_OFS, 32'h11);
      tick(3);
      chk("muted", 32'h0, {31'h0, tc_out_enable});
      paused <= 1'b1;
      tick(3);
      chk("pause out", 32'h1, {31'h0, tc_out_enable});
      paused <= 1'b0;
      wr(TCMC_CTRL_OFS, 32'h61);
      tick(80);
      chk("no int sync", 32'h0, {31'h0, audio_clk_ext});
      wr(TCMC_CTRL_OFS, 32'h14);
      tick(80);
      chk("chase no mute", 32'h1, {31'h0, tc_out_enable});
      $display("free run test done");
      rtc_time <= R1V[21:0];
      wr(TCMC_CTRL_OFS, 32'h3);
      tick(2);
      rc("rtc entry", TCMC_COUNT_OFS, R1V, MK);
      rtc_time <= R2V[21:0];
      wr(TCMC_CMD_OFS, 32'h4);
      tick(2);
      rc("rtc change", TCMC_COUNT_OFS, R2V, MK);
      $display("rtc test done");
      gen_run <= 1'b0;
      tick(LS + 50);
      wr(TCMC_CTRL_OFS, 32'h45);
      gen_run <= 1'b1;
      for (i = 0; i < 150 && auto_rec_start !== 1'b1; i++) tick(1);
      chk("arec start", 32'h1, {31'h0, auto_rec_start});
      recording <= 1'b1;
      @(negedge tc_in_strobe);
      tick(4);
      rc("chase", TCMC_COUNT_OFS, {10'h0, tc_in_value}, '1);
      rc("valid", TCMC_STATUS_OFS, 32'h1, 32'h1);
      chk("sync", 32'h1, {31'h0, audio_clk_ext});
      gen_run <= 1'b0;
      for (i = 0; i < LS + 100 && auto_rec_stop !== 1'b1; i++) tick(1);
      chk("arec stop", 32'h1, {31'h0, auto_rec_stop});
      recording <= 1'b0;
      tick(3);
      chk("int clock", 32'h0, {31'h0, audio_clk_ext});
      wr(TCMC_CTRL_OFS, 32'h24);
      rd(TCMC_COUNT_OFS, v);
      tick(3 * FR);
      rd(TCMC_COUNT_OFS, w);
      chk("continuity", 32'h1, {31'h0, w !== v});
      $display("chase test done");
      gen_run <= 1'b1;
      recording <= 1'b1;
      wr(TCMC_CTRL_OFS, 32'h0);
      tick(120);
      chk("off out", 32'h0, {31'h0, tc_out_enable});
      chk("off embed", 32'h0, {31'h0, file_tc_valid});
      $display("off test done");
      tally_and_finish();
   end
endmodule
